// file: logic/pdc_ctrl_top.sv
// Pre-driver channel control: configuration registers, output gating, reset flags
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/100ps

module pdc_ctrl_top (
  input  wire logic                                 clk_i,
  input  wire logic                                 reset_n_i,
  input  wire logic [pdc_pkg::ADDR_W-1:0]           addr_i,
  input  wire logic [pdc_pkg::DATA_W-1:0]           wdata_i,
  input  wire logic                                 wr_i,
  input  wire logic                                 rd_i,
  output logic      [pdc_pkg::DATA_W-1:0]           rdata_o,
  input  wire logic                                 external_reset_input_n_i,
  input  wire logic                                 channel_six_enable_pin_i,
  input  wire logic [pdc_pkg::NUM_CH-1:0]           active_low_on_input_n_i,
  input  wire logic                                 sdo_ov_i,
  input  wire logic                                 cs_n_i,
  input  wire logic                                 sdo_data_i,
  output logic                                      sdo_o,
  output logic                                      sdo_oe_o,
  output logic                                      sdo_backfeed_block_o,
  output logic      [pdc_pkg::NUM_CH-1:0]           gate_on_o,
  output logic      [pdc_pkg::NUM_CH-1:0]           channel_output_enable_o,
  output pdc_pkg::pdc_chan_cfg_t [pdc_pkg::NUM_CH-1:0] chan_cfg_o,
  output logic                                      charge_pump_en_o,
  output logic                                      openload_diag_en_o,
  output logic                                      irq_o
);

  localparam int unsigned NCH = pdc_pkg::NUM_CH;

  // Address match for one register
  function automatic logic hit(input logic [pdc_pkg::ADDR_W-1:0] a,
                               input logic [pdc_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // Selected on/off control of one channel
  function automatic logic sel_on(input logic src, input logic reg_on, input logic pin_n);
    sel_on = src ? reg_on : ~pin_n;
  endfunction

  logic                   ext_meta_q;
  logic                   ext_n_q;
  logic                   ext_prev_q;
  logic                   ext_active;
  logic                   ch6_meta_q;
  logic                   ch6_q;
  logic                   ch6_prev_q;
  logic                   ch6_fall;
  logic [NCH-1:0]         non_meta_q;
  logic [NCH-1:0]         non_q;
  logic [NCH-1:0]         side_q;
  logic [NCH-1:0]         fet_q;
  logic [NCH-1:0]         en_q;
  logic [NCH-1:0]         src_q;
  logic [NCH-1:0]         on_q;
  logic [2*NCH-1:0]       gcc_q;
  logic [NCH-1:0]         drive_en_d;
  logic [NCH-1:0]         gate_on_d;
  logic [pdc_pkg::FLG_W-1:0] flags_q;
  logic [pdc_pkg::FLG_W-1:0] flag_set;
  logic [pdc_pkg::IRQ_W-1:0] irq_stat_q;
  logic [pdc_pkg::IRQ_W-1:0] irq_en_q;
  logic [pdc_pkg::IRQ_W-1:0] irq_set;
  logic                   rd_flags;
  logic                   sdo_ov_evt;
  logic                   pump_q;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_meta_q <= 1'b0;
      ext_n_q    <= 1'b0;
      ext_prev_q <= 1'b1;
      ch6_meta_q <= 1'b0;
      ch6_q      <= 1'b0;
      ch6_prev_q <= 1'b0;
      non_meta_q <= '1;
      non_q      <= '1;
    end else begin
      ext_meta_q <= external_reset_input_n_i;
      ext_n_q    <= ext_meta_q;
      ext_prev_q <= ext_active;
      ch6_meta_q <= channel_six_enable_pin_i;
      ch6_q      <= ch6_meta_q;
      ch6_prev_q <= ch6_q;
      non_meta_q <= active_low_on_input_n_i;
      non_q      <= non_meta_q;
    end
  end

  // Active low input; internal reset is the OR with power-on reset
  assign ext_active = ~ext_n_q;
  // Disable counts only when channel six was actually enabled
  assign ch6_fall   = ch6_prev_q & ~ch6_q & en_q[pdc_pkg::CH6_IDX];
  assign rd_flags   = rd_i & hit(addr_i, pdc_pkg::OFF_FLAGS);

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers; external reset returns them to defaults
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      side_q <= pdc_pkg::RST_SIDE;
      fet_q  <= pdc_pkg::RST_FET;
      en_q   <= pdc_pkg::RST_ENABLE;
      src_q  <= pdc_pkg::RST_SRC;
      on_q   <= pdc_pkg::RST_ON;
      gcc_q  <= pdc_pkg::RST_GCC;
    end else if (ext_active) begin
      side_q <= pdc_pkg::RST_SIDE;
      fet_q  <= pdc_pkg::RST_FET;
      en_q   <= pdc_pkg::RST_ENABLE;
      src_q  <= pdc_pkg::RST_SRC;
      on_q   <= pdc_pkg::RST_ON;
      gcc_q  <= pdc_pkg::RST_GCC;
    end else if (wr_i) begin
      if (hit(addr_i, pdc_pkg::OFF_SIDE))   side_q <= wdata_i[NCH-1:0];
      if (hit(addr_i, pdc_pkg::OFF_FET))    fet_q  <= wdata_i[NCH-1:0];
      if (hit(addr_i, pdc_pkg::OFF_ENABLE)) en_q   <= wdata_i[NCH-1:0];
      if (hit(addr_i, pdc_pkg::OFF_SRC))    src_q  <= wdata_i[NCH-1:0];
      if (hit(addr_i, pdc_pkg::OFF_ON))     on_q   <= wdata_i[NCH-1:0];
      if (hit(addr_i, pdc_pkg::OFF_GCC))    gcc_q  <= wdata_i[2*NCH-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel gating: enable bit, channel six pin, and no external reset
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      drive_en_d[i] = en_q[i] & ~ext_active;
      gate_on_d[i]  = sel_on(src_q[i], on_q[i], non_q[i]);
    end
    drive_en_d[pdc_pkg::CH6_IDX] = en_q[pdc_pkg::CH6_IDX] & ch6_q & ~ext_active;
  end

  // Gate outputs from flops; a disabled channel is also forced off
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      channel_output_enable_o <= '0;
      gate_on_o               <= '0;
    end else begin
      channel_output_enable_o <= drive_en_d;
      gate_on_o               <= drive_en_d & gate_on_d;
    end
  end

  // Static per-channel setup as seen by the gate stage
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      chan_cfg_o[i].high_side    = side_q[i];
      chan_cfg_o[i].p_type       = fet_q[i];
      chan_cfg_o[i].gate_current = pdc_pkg::pdc_gcc_t'(gcc_q[2*i +: 2]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pump and open-load regulators run only with both resets released
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) pump_q <= 1'b0;
    else pump_q <= ~ext_active;
  end

  assign charge_pump_en_o   = pump_q;
  assign openload_diag_en_o = pump_q;

  //////////////////////////////////////////////////////////////////////////////
  // Serial output guard
  pdc_sdo_guard pdc_sdo_guard_i (
    .clk_i            (clk_i),
    .reset_n_i        (reset_n_i),
    .clear_i          (ext_active),
    .sdo_ov_i         (sdo_ov_i),
    .cs_n_i           (cs_n_i),
    .sdo_data_i       (sdo_data_i),
    .sdo_o            (sdo_o),
    .sdo_oe_o         (sdo_oe_o),
    .backfeed_block_o (sdo_backfeed_block_o),
    .ov_event_o       (sdo_ov_evt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Read-to-clear flags; a set in the reading cycle survives the clear
  always_comb begin
    flag_set                   = '0;
    flag_set[pdc_pkg::FLG_EXT] = ext_active;
    flag_set[pdc_pkg::FLG_CH6] = ch6_fall;
    flag_set[pdc_pkg::FLG_SDO] = sdo_ov_evt;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_q <= pdc_pkg::RST_FLAGS;  // Power-on flag set
    end else if (ext_active) begin
      // Diagnostics dropped, external reset flag held set, power-on flag still cleared by a read
      flags_q[pdc_pkg::FLG_EXT] <= 1'b1;
      flags_q[pdc_pkg::FLG_CH6] <= 1'b0;
      flags_q[pdc_pkg::FLG_SDO] <= 1'b0;
      if (rd_flags) flags_q[pdc_pkg::FLG_POR] <= 1'b0;
    end else if (rd_flags) begin
      flags_q <= flag_set;
    end else begin
      flags_q <= flags_q | flag_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, write-one-to-clear via a separate register
  assign irq_set = {sdo_ov_evt, ch6_fall, ext_active & ~ext_prev_q};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat_q <= pdc_pkg::RST_IRQ;
      irq_en_q   <= pdc_pkg::RST_IRQ;
    end else begin
      if (wr_i && hit(addr_i, pdc_pkg::OFF_IRQ_CLR)) begin
        irq_stat_q <= (irq_stat_q & ~wdata_i[pdc_pkg::IRQ_W-1:0]) | irq_set;  // Set wins
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      if (wr_i && hit(addr_i, pdc_pkg::OFF_IRQ_EN)) irq_en_q <= wdata_i[pdc_pkg::IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat_q & irq_en_q);

  //////////////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= '0;
      case (addr_i)
        pdc_pkg::OFF_SIDE:     rdata_o[NCH-1:0] <= side_q;
        pdc_pkg::OFF_FET:      rdata_o[NCH-1:0] <= fet_q;
        pdc_pkg::OFF_ENABLE:   rdata_o[NCH-1:0] <= en_q;
        pdc_pkg::OFF_SRC:      rdata_o[NCH-1:0] <= src_q;
        pdc_pkg::OFF_ON:       rdata_o[NCH-1:0] <= on_q;
        pdc_pkg::OFF_GCC:      rdata_o[2*NCH-1:0] <= gcc_q;
        pdc_pkg::OFF_FLAGS: begin
          rdata_o[pdc_pkg::FLG_W-1:0]      <= flags_q;
          rdata_o[pdc_pkg::FLG_CH6_LVL]    <= ch6_q;  // Live pin level
        end
        pdc_pkg::OFF_IRQ_STAT: rdata_o[pdc_pkg::IRQ_W-1:0] <= irq_stat_q;
        pdc_pkg::OFF_IRQ_EN:   rdata_o[pdc_pkg::IRQ_W-1:0] <= irq_en_q;
        default:               rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_ext_held;
    ext_active ##1 ext_active;
  endsequence

  AST_EXT_RESET_OFF: assert property (ext_active |=> channel_output_enable_o == '0 &&
    gate_on_o == '0) else $error("Output driven under external reset");

  AST_EXT_PUMP_OFF: assert property (s_ext_held |-> !charge_pump_en_o &&
    !openload_diag_en_o) else $error("Pump or diagnosis on under reset");

  AST_DEFAULT_CFG: assert property (ext_active |=> side_q == '0 && fet_q == '0 &&
    en_q == '0) else $error("Configuration not defaulted by reset");

  AST_CH6_AND: assert property (!ch6_q |=> !channel_output_enable_o[pdc_pkg::CH6_IDX])
    else $error("Channel six driven with pin low");

  AST_SRC_REGISTER: assert property (src_q[0] && en_q[0] && !ext_active && on_q[0]
    |=> gate_on_o[0]) else $error("Register control not followed");

  AST_SRC_PIN: assert property (!src_q[1] && en_q[1] && !ext_active && non_q[1]
    |=> !gate_on_o[1]) else $error("Pin control not followed");

  AST_POR_FLAG_CLEAR: assert property (rd_flags |=> !flags_q[pdc_pkg::FLG_POR])
    else $error("Power-on flag not cleared by read");

  AST_EXT_FLAG: assert property (ext_active |=> flags_q[pdc_pkg::FLG_EXT])
    else $error("External reset flag not set");

  AST_SET_WINS: assert property (rd_flags && sdo_ov_evt && !ext_active
    |=> flags_q[pdc_pkg::FLG_SDO]) else $error("Event lost in read-clear cycle");

  AST_CH6_FLAG: assert property (ch6_fall && !ext_active |=> flags_q[pdc_pkg::FLG_CH6])
    else $error("Channel six disable not latched");

  sequence s_ext_released;
    !ext_active ##1 !ext_active;
  endsequence

  AST_PUMP_RESUME: assert property (s_ext_released |-> charge_pump_en_o)
    else $error("Pump off after both resets released");

  AST_IRQ_EXT_EDGE: assert property (ext_active && !ext_prev_q |=>
    irq_stat_q[pdc_pkg::IRQ_EXT]) else $error("External reset interrupt not latched");

  AST_POR_FLAG_HELD: assert property (flags_q[pdc_pkg::FLG_POR] && !rd_flags |=>
    flags_q[pdc_pkg::FLG_POR]) else $error("Power-on flag lost without read");

  AST_SDO_FLAG_SET: assert property (sdo_ov_evt && !ext_active |=>
    flags_q[pdc_pkg::FLG_SDO]) else $error("Serial overvoltage not latched");

  AST_SDO_FLAG_STICKY: assert property (flags_q[pdc_pkg::FLG_SDO] && !rd_flags &&
    !ext_active |=> flags_q[pdc_pkg::FLG_SDO]) else $error("Serial overvoltage flag lost");

  AST_CH6_FLAG_CLEAR: assert property (rd_flags && !ch6_fall && !ext_active |=>
    !flags_q[pdc_pkg::FLG_CH6]) else $error("Channel six flag not cleared by read");

  AST_CH6_LEVEL_READ: assert property (rd_flags |=>
    rdata_o[pdc_pkg::FLG_CH6_LVL] == $past(ch6_q)) else $error("Channel six level misread");

  AST_DISABLED_OFF: assert property (!en_q[2] |=>
    !channel_output_enable_o[2] && !gate_on_o[2]) else $error("Disabled channel driven");

  AST_CFG_HOLD: assert property (!wr_i && !ext_active |=> $stable(side_q))
    else $error("Side selection changed without a write");

  AST_SIDE_WRITE: assert property (wr_i && !ext_active && wdata_i[0] &&
    hit(addr_i, pdc_pkg::OFF_SIDE) |=> chan_cfg_o[0].high_side)
    else $error("High-side selection not applied");

  AST_GCC_CODE: assert property (wr_i && !ext_active && wdata_i[3:2] == 2'h2 &&
    hit(addr_i, pdc_pkg::OFF_GCC) |=> chan_cfg_o[1].gate_current == pdc_pkg::PDC_GCC_5MA)
    else $error("Gate current code not applied");

endmodule // pdc_ctrl_top

// file: logic/pdc_pkg.sv
// Package: register map, field layout and reset values of the pre-driver channel control
package pdc_pkg;

  // Channel count and bus widths
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;

  // Register offsets (byte addresses)
  localparam logic [5:0] OFF_SIDE     = 6'h00;
  localparam logic [5:0] OFF_FET      = 6'h04;
  localparam logic [5:0] OFF_ENABLE   = 6'h08;
  localparam logic [5:0] OFF_SRC      = 6'h0C;
  localparam logic [5:0] OFF_ON       = 6'h10;
  localparam logic [5:0] OFF_GCC      = 6'h14;
  localparam logic [5:0] OFF_FLAGS    = 6'h18;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h1C;
  localparam logic [5:0] OFF_IRQ_CLR  = 6'h20;
  localparam logic [5:0] OFF_IRQ_EN   = 6'h24;

  // Bit positions in the read-to-clear flag register
  localparam int unsigned FLG_POR     = 0;
  localparam int unsigned FLG_EXT     = 1;
  localparam int unsigned FLG_CH6     = 2;
  localparam int unsigned FLG_SDO     = 3;
  localparam int unsigned FLG_CH6_LVL = 4;
  localparam int unsigned FLG_W       = 4;

  // Bit positions in the interrupt status, clear and enable registers
  localparam int unsigned IRQ_EXT = 0;
  localparam int unsigned IRQ_CH6 = 1;
  localparam int unsigned IRQ_SDO = 2;
  localparam int unsigned IRQ_W   = 3;

  // Channel six index (zero based)
  localparam int unsigned CH6_IDX = 5;

  // Reset values
  localparam logic [7:0]  RST_SIDE   = 8'h00;  // Low side on every channel
  localparam logic [7:0]  RST_FET    = 8'h00;  // N-type on every channel
  localparam logic [7:0]  RST_ENABLE = 8'h00;  // Every channel three-stated
  localparam logic [7:0]  RST_SRC    = 8'h00;
  localparam logic [7:0]  RST_ON     = 8'h00;
  localparam logic [15:0] RST_GCC    = 16'h0000;
  localparam logic [3:0]  RST_FLAGS  = 4'h1;   // Power-on flag set out of reset
  localparam logic [2:0]  RST_IRQ    = 3'h0;

  // Gate current codes
  typedef enum logic [1:0] {
    PDC_GCC_MAX  = 2'h0,
    PDC_GCC_20MA = 2'h1,
    PDC_GCC_5MA  = 2'h2,
    PDC_GCC_1MA  = 2'h3
  } pdc_gcc_t;

  // Static configuration of one channel as seen by its gate stage
  typedef struct packed {
    logic     high_side;
    logic     p_type;
    pdc_gcc_t gate_current;
  } pdc_chan_cfg_t;

  // Serial output guard states, Gray coded along run, block, wait
  typedef enum logic [1:0] {
    PDC_SDO_RUN   = 2'h0,
    PDC_SDO_BLOCK = 2'h1,
    PDC_SDO_WAIT  = 2'h3
  } pdc_sdo_state_t;

endpackage

// file: logic/pdc_sdo_guard.sv
// Serial data output overvoltage guard with chip-select re-arm
`timescale 1ns/100ps
module pdc_sdo_guard (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic clear_i,
  input  wire logic sdo_ov_i,
  input  wire logic cs_n_i,
  input  wire logic sdo_data_i,
  output logic      sdo_o,
  output logic      sdo_oe_o,
  output logic      backfeed_block_o,
  output logic      ov_event_o
);

  logic                    ov_meta_q;
  logic                    ov_q;
  logic                    ov_prev_q;
  logic                    cs_meta_q;
  logic                    cs_q;
  logic                    cs_prev_q;
  logic                    cs_rise;
  pdc_pkg::pdc_sdo_state_t state_q;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edges are taken from the second stage only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ov_meta_q <= 1'b0;
      ov_q      <= 1'b0;
      ov_prev_q <= 1'b0;
      cs_meta_q <= 1'b1;
      cs_q      <= 1'b1;
      cs_prev_q <= 1'b1;
    end else begin
      ov_meta_q <= sdo_ov_i;
      ov_q      <= ov_meta_q;
      ov_prev_q <= ov_q;
      cs_meta_q <= cs_n_i;
      cs_q      <= cs_meta_q;
      cs_prev_q <= cs_q;
    end
  end

  assign cs_rise    = cs_q & ~cs_prev_q;
  assign ov_event_o = ov_q & ~ov_prev_q;  // One pulse per overvoltage episode

  //////////////////////////////////////////////////////////////////////////////
  // Driver state: off while overvoltage, then wait for chip-select release
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= pdc_pkg::PDC_SDO_RUN;
    end else if (clear_i) begin
      state_q <= pdc_pkg::PDC_SDO_RUN;  // Protection state is dropped on reset
    end else begin
      case (state_q)
        pdc_pkg::PDC_SDO_RUN: begin
          if (ov_q) state_q <= pdc_pkg::PDC_SDO_BLOCK;
        end
        pdc_pkg::PDC_SDO_BLOCK: begin
          if (!ov_q) state_q <= pdc_pkg::PDC_SDO_WAIT;
        end
        pdc_pkg::PDC_SDO_WAIT: begin
          if (ov_q) state_q <= pdc_pkg::PDC_SDO_BLOCK;
          else if (cs_rise) state_q <= pdc_pkg::PDC_SDO_RUN;
        end
        default: state_q <= pdc_pkg::PDC_SDO_BLOCK;
      endcase
    end
  end

  // Data from a flop; enable only while selected and not blocked
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) sdo_o <= 1'b0;
    else sdo_o <= sdo_data_i;
  end

  assign sdo_oe_o         = (state_q == pdc_pkg::PDC_SDO_RUN) & ~cs_q & ~ov_q;
  assign backfeed_block_o = (state_q != pdc_pkg::PDC_SDO_RUN) | ov_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_SDO_OFF_ON_OV: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ov_q |-> !sdo_oe_o && backfeed_block_o) else $error("SDO driven during overvoltage");

  sequence s_blocked_no_edge;
    (state_q != pdc_pkg::PDC_SDO_RUN) && !cs_rise && !clear_i;
  endsequence

  AST_SDO_REARM_ON_CS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_blocked_no_edge |=> !sdo_oe_o) else $error("SDO re-enabled without CS rise");

endmodule // pdc_sdo_guard

// file: testbench/pdc_ctrl_top_tb.sv
// Register-level testbench of the pre-driver channel control
`timescale 1ns/100ps
module pdc_ctrl_top_tb;
  logic                 clk_i = 1'b0;
  logic                 reset_n_i = 1'b1;
  logic [5:0]           addr_i = 6'h00;
  logic [31:0]          wdata_i = 32'h0;
  logic                 wr_i = 1'b0;
  logic                 rd_i = 1'b0;
  logic [31:0]          rdata_o;
  logic                 ext_drv = 1'b0;
  logic                 ext_lvl = 1'b1;
  logic                 ext_pin;
  logic                 ch6 = 1'b1;
  logic [7:0]           on_n = 8'hFF;
  logic                 ov = 1'b0;
  logic                 cs_n = 1'b1;
  logic                 sdo_o, sdo_oe, bfb, pump, diag, irq;
  logic [7:0]           gate_on, oe;
  logic [31:0]          cfg, exp_cfg;
  int                   err_count = 0;
  int                   n_compared = 0;

  always #50 clk_i = ~clk_i;

  pdc_pins_model pdc_pins_model_i (.drive_en_i(ext_drv), .drive_lvl_i(ext_lvl),
    .ext_pin_o(ext_pin));

  pdc_ctrl_top pdc_ctrl_top_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .external_reset_input_n_i(ext_pin), .channel_six_enable_pin_i(ch6),
    .active_low_on_input_n_i(on_n), .sdo_ov_i(ov), .cs_n_i(cs_n), .sdo_data_i(1'b1),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe), .sdo_backfeed_block_o(bfb), .gate_on_o(gate_on),
    .channel_output_enable_o(oe), .chan_cfg_o(cfg), .charge_pump_en_o(pump),
    .openload_diag_en_o(diag), .irq_o(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One-cycle write strobe, taken at the next edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so sample it there
  task automatic rchk(input string n, input logic [5:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(n, rdata_o, e);
  endtask

  // Bounded wait for the serial driver enable to reach a level
  task automatic wait_oe(input logic v);
    int k;
    for (k = 0; k < 20 && sdo_oe !== v; k++) @(posedge clk_i);
    if (sdo_oe !== v) begin
      err_count++;
      $display("MISMATCH sdo_oe wait expected %h", v);
      end_of_test();
    end
  endtask

  // Power-on reset pulse; outputs must be off while it is held
  task automatic por();
    reset_n_i <= 1'b0;
    #1;
    chk("oe in reset", oe, 32'h0);
    cyc(12);
    chk("pump in reset", {pump, diag, sdo_oe}, 32'h0);
    reset_n_i <= 1'b1;
    cyc(5);
    rchk("flags after por", pdc_pkg::OFF_FLAGS, 32'h13);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    por();
    rchk("flags cleared", pdc_pkg::OFF_FLAGS, 32'h10);
    rchk("side", pdc_pkg::OFF_SIDE, 32'h0);
    rchk("fet", pdc_pkg::OFF_FET, 32'h0);
    rchk("enable", pdc_pkg::OFF_ENABLE, 32'h0);
    chk("cfg default", cfg, 32'h0);
    chk("pump diag", {pump, diag}, 32'h3);
    rchk("unmapped", 6'h3C, 32'h0);
    $display("test reset defaults done");

    // Every gate current code on the first four channels, mixed side and type
    wr(pdc_pkg::OFF_SIDE, 32'h0F);
    wr(pdc_pkg::OFF_FET, 32'h05);
    wr(pdc_pkg::OFF_GCC, 32'hE4E4);
    cyc(2);
    for (int i = 0; i < 8; i++) exp_cfg[4*i+:4] = {i < 4, i == 0 || i == 2, 2'(i % 4)};
    chk("chan cfg", cfg, exp_cfg);
    rchk("gcc", pdc_pkg::OFF_GCC, 32'hE4E4);
    $display("test configuration done");

    // Low nibble follows pins, high nibble follows register on-bits
    on_n <= 8'h05;
    wr(pdc_pkg::OFF_SRC, 32'hF0);
    wr(pdc_pkg::OFF_ON, 32'hA0);
    wr(pdc_pkg::OFF_ENABLE, 32'hFF);
    cyc(5);
    chk("oe all", oe, 32'hFF);
    chk("gate on", gate_on, 32'hAA);
    on_n <= 8'h0A;
    cyc(5);
    chk("gate on pins", gate_on, 32'hA5);
    ch6 <= 1'b0;
    cyc(5);
    chk("oe ch6 pin low", oe, 32'hDF);
    rchk("ch6 flag", pdc_pkg::OFF_FLAGS, 32'h04);
    ch6 <= 1'b1;
    cyc(5);
    chk("oe ch6 back", oe, 32'hFF);
    rchk("ch6 level", pdc_pkg::OFF_FLAGS, 32'h10);
    $display("test channel control done");

    // Overvoltage cuts the serial driver until chip select rises again
    rchk("irq ch6", pdc_pkg::OFF_IRQ_STAT, 32'h2);
    chk("irq idle", irq, 32'h0);
    wr(pdc_pkg::OFF_IRQ_CLR, 32'h2);
    wr(pdc_pkg::OFF_IRQ_EN, 32'h7);
    cs_n <= 1'b0;
    wait_oe(1'b1);
    ov <= 1'b1;
    wait_oe(1'b0);
    chk("backfeed", bfb, 32'h1);
    cyc(2);
    chk("irq", irq, 32'h1);
    rchk("irq status", pdc_pkg::OFF_IRQ_STAT, 32'h4);
    ov <= 1'b0;
    cyc(6);
    chk("oe held off", sdo_oe, 32'h0);
    cs_n <= 1'b1;
    cyc(4);
    cs_n <= 1'b0;
    cyc(4);
    chk("oe rearmed", sdo_oe, 32'h1);
    chk("sdo data", sdo_o, 32'h1);
    rchk("sdo flag", pdc_pkg::OFF_FLAGS, 32'h18);
    rchk("sdo flag cleared", pdc_pkg::OFF_FLAGS, 32'h10);
    wr(pdc_pkg::OFF_IRQ_CLR, 32'h4);
    cyc(1);
    chk("irq cleared", irq, 32'h0);
    wr(pdc_pkg::OFF_IRQ_EN, 32'h0);
    ov <= 1'b1;
    cyc(6);
    chk("irq masked", irq, 32'h0);
    ov <= 1'b0;
    $display("test serial overvoltage done");

    // External reset: outputs off, writes refused, flag held across reads
    ext_drv <= 1'b1;
    ext_lvl <= 1'b0;
    cyc(5);
    chk("oe ext", oe, 32'h0);
    chk("pump diag ext", {pump, diag}, 32'h0);
    chk("cfg ext", cfg, 32'h0);
    wr(pdc_pkg::OFF_ENABLE, 32'hFF);
    rchk("enable refused", pdc_pkg::OFF_ENABLE, 32'h0);
    rchk("ext flag", pdc_pkg::OFF_FLAGS, 32'h12);
    rchk("ext flag kept", pdc_pkg::OFF_FLAGS, 32'h12);
    ext_drv <= 1'b0;
    cyc(6);
    chk("pump back", pump, 32'h1);
    rchk("ext flag last", pdc_pkg::OFF_FLAGS, 32'h12);
    rchk("ext flag gone", pdc_pkg::OFF_FLAGS, 32'h10);
    rchk("irq ext", pdc_pkg::OFF_IRQ_STAT, 32'h5);
    $display("test external reset done");

    // Power-on reset in mid-run drops enables at once and sets the power-on flag
    wr(pdc_pkg::OFF_ENABLE, 32'h01);
    cyc(3);
    chk("oe before por", oe, 32'h01);
    por();
    $display("test second reset done");
    end_of_test();
  end
endmodule  // pdc_ctrl_top_tb

// file: testbench/pdc_pins_model.sv
// Far-side pin model: host reset line with pull-up, driven only when asked
`timescale 1ns/100ps
module pdc_pins_model (
  input  wire logic drive_en_i,
  input  wire logic drive_lvl_i,
  output logic      ext_pin_o
);
  // Released line floats to the pull-up, so the reset stays idle
  assign ext_pin_o = drive_en_i ? drive_lvl_i : 1'b1;
endmodule  // pdc_pins_model
